/* hw/bmt_pkg.sv */
package bmt_pkg;

  // clock and reset sequencing timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEADY_NS = 50;
  localparam int STEADY_CYC = (STEADY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // array geometry
  localparam int MEM_BITS = 9216;
  localparam int POW2_BITS = 8192;
  localparam int BIT_W = 14;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 18;
  localparam int PTR_W = 15;

  // preload image layout in the user flash store
  localparam int INIT_W = 9;
  localparam int INIT_WORDS = 1024;
  localparam int INIT_IDX_W = 10;
  localparam int UFS_AW = 12;
  localparam int UFS_WORDS = 4096;
  localparam logic [17:0] DATA_ZERO = 18'h0_0000;

  typedef enum logic [1:0] {MODE_SP, MODE_TDP, MODE_PDP, MODE_FIFO} bmt_mode_e;
  typedef enum logic [2:0] {RK_ASYNC, RK_GLOBAL, RK_FIFO, RK_RPTR, RK_SYNC} bmt_rkind_e;

  // words per port for a given data width, 0 when the width is not offered
  function automatic int bmt_depth(input int w);
    case (w)
      1: return 8192;
      2: return 4096;
      4: return 2048;
      9: return 1024;
      18: return 512;
      default: return 0;
    endcase
  endfunction

  // the 18-bit width exists only in pseudo dual port and fifo modes
  function automatic bit bmt_width_ok(input bmt_mode_e m, input int w);
    if (w == 18) begin
      return (m == MODE_PDP) || (m == MODE_FIFO);
    end
    return bmt_depth(w) != 0;
  endfunction

  // usable bits for a width family: parity widths reach the full array
  function automatic int bmt_cap(input int w);
    return (w % 9 == 0) ? MEM_BITS : POW2_BITS;
  endfunction

  // fifo bit pointer step, wrapping at twice the capacity
  function automatic logic [PTR_W-1:0] bmt_ptr_adv(input logic [PTR_W-1:0] p, input int w,
                                                    input int cap);
    int n;
    n = int'(p) + w;
    if (n >= 2 * cap) begin
      n = n - 2 * cap;
    end
    return PTR_W'(n);
  endfunction

endpackage

/* hw/bmt_if.sv */
`timescale 1ns/1ns
// tile ports as seen between the fabric logic and the block memory tile
interface bmt_if;
  import bmt_pkg::*;
  logic ce_a;
  logic we_a;
  logic [ADDR_W-1:0] addr_a;
  logic [DATA_W-1:0] wdata_a;
  logic [DATA_W-1:0] rdata_a;
  logic ce_b;
  logic we_b;
  logic [ADDR_W-1:0] addr_b;
  logic [DATA_W-1:0] wdata_b;
  logic [DATA_W-1:0] rdata_b;
  logic push;
  logic pop_strobe;
  logic full;
  logic empty;
  logic global_set_reset;
  logic tile_async_reset;
  logic sync_reset;
  logic fifo_reset;
  logic read_pointer_reset;

  modport tile (
    input ce_a, we_a, addr_a, wdata_a, ce_b, we_b, addr_b, wdata_b, push, pop_strobe,
    input global_set_reset, tile_async_reset, sync_reset, fifo_reset, read_pointer_reset,
    output rdata_a, rdata_b, full, empty
  );

  modport user (
    output ce_a, we_a, addr_a, wdata_a, ce_b, we_b, addr_b, wdata_b, push, pop_strobe,
    output global_set_reset, tile_async_reset, sync_reset, fifo_reset, read_pointer_reset,
    input rdata_a, rdata_b, full, empty
  );
endinterface

/* hw/bmt_user.sv */
`timescale 1ns/1ns
// fabric side: passes user traffic to the tile and sequences its resets
module bmt_user #(
  parameter bmt_pkg::bmt_mode_e MODE = bmt_pkg::MODE_TDP,
  parameter bit GLOBAL_EN = 1'b1,
  parameter bit PRELOADED = 1'b0,
  parameter int HOLD_CYC = bmt_pkg::STEADY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  bmt_if.user tile,
  input wire logic usr_ce_a,
  input wire logic usr_we_a,
  input wire logic [bmt_pkg::ADDR_W-1:0] usr_addr_a,
  input wire logic [bmt_pkg::DATA_W-1:0] usr_wdata_a,
  output logic [bmt_pkg::DATA_W-1:0] usr_rdata_a,
  input wire logic usr_ce_b,
  input wire logic usr_we_b,
  input wire logic [bmt_pkg::ADDR_W-1:0] usr_addr_b,
  input wire logic [bmt_pkg::DATA_W-1:0] usr_wdata_b,
  output logic [bmt_pkg::DATA_W-1:0] usr_rdata_b,
  input wire logic usr_push,
  input wire logic usr_pop,
  output logic usr_full,
  output logic usr_empty,
  input wire logic rst_req,
  input wire bmt_pkg::bmt_rkind_e rst_kind,
  output logic rst_busy,
  output logic rst_refused
);
  import bmt_pkg::*;

  typedef enum logic [1:0] {U_IDLE, U_QUIET, U_HOLD, U_TAIL} bmt_useq_e;

  if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_bad_hold
    $error("bmt_user: HOLD_CYC out of range");
  end

  bmt_useq_e seq;
  bmt_rkind_e kind;
  logic [7:0] hold_cnt;
  logic glob_q, arst_q, srst_q, frst_q, rprst_q;

  // request decode: sync reset needs no sequencing only with the global input off
  wire is_plain_sync = (rst_kind == RK_SYNC) && !GLOBAL_EN;      // [R16]
  wire is_refused = rst_req && (rst_kind == RK_GLOBAL) && PRELOADED; // [R12]
  wire starts_seq = rst_req && (seq == U_IDLE) && !is_refused && !is_plain_sync;
  wire in_seq = (seq != U_IDLE);
  // flop input leads by one, so the lines stand exactly over the hold cycles
  wire drive_rst = (seq == U_QUIET) || ((seq == U_HOLD) && (hold_cnt != 8'h00)); // [R9]

  // which enables go quiet: all for tile, global and sync resets, both fifo strobes for fifo resets, pop only for pointer resets
  wire gate_ce = in_seq && (kind == RK_ASYNC || kind == RK_GLOBAL || kind == RK_SYNC); // [R9]
  wire gate_push = in_seq && (kind != RK_RPTR);                   // [R13] [R14]
  wire gate_pop = in_seq;                                         // [R14]

  // sequence: one quiet cycle, reset held steady, one quiet cycle after release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq <= U_IDLE;
      kind <= RK_ASYNC;
      hold_cnt <= 8'h00;
    end else begin
      case (seq)
        U_IDLE: begin
          if (starts_seq) begin
            seq <= U_QUIET;                                       // [R9]
            kind <= rst_kind;
          end
        end
        U_QUIET: begin
          seq <= U_HOLD;
          hold_cnt <= 8'(HOLD_CYC - 1);
        end
        U_HOLD: begin
          if (hold_cnt == 8'h00) begin
            seq <= U_TAIL;                                        // [R11]
          end else begin
            hold_cnt <= hold_cnt - 8'h01;
          end
        end
        U_TAIL: seq <= U_IDLE;                                    // [R9]
        default: seq <= U_IDLE;
      endcase
    end
  end

  // reset lines to the tile come from flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      glob_q <= 1'b0;
      arst_q <= 1'b0;
      srst_q <= 1'b0;
      frst_q <= 1'b0;
      rprst_q <= 1'b0;
      rst_refused <= 1'b0;
    end else begin
      glob_q <= drive_rst && (kind == RK_GLOBAL);
      arst_q <= drive_rst && (kind == RK_ASYNC);
      srst_q <= (drive_rst && kind == RK_SYNC) || (rst_req && is_plain_sync); // [R16]
      frst_q <= drive_rst && (kind == RK_FIFO);
      rprst_q <= drive_rst && (kind == RK_RPTR);
      rst_refused <= is_refused;
    end
  end

  // traffic pass-through with enables held low around resets
  assign tile.ce_a = usr_ce_a && !gate_ce;
  assign tile.we_a = usr_we_a;
  assign tile.addr_a = usr_addr_a;
  assign tile.wdata_a = usr_wdata_a;
  assign tile.ce_b = usr_ce_b && !gate_ce;
  assign tile.we_b = usr_we_b;
  assign tile.addr_b = usr_addr_b;
  assign tile.wdata_b = usr_wdata_b;
  assign tile.push = usr_push && !gate_push && (MODE == MODE_FIFO);
  assign tile.pop_strobe = usr_pop && !gate_pop && (MODE == MODE_FIFO);
  assign tile.global_set_reset = glob_q;
  assign tile.tile_async_reset = arst_q;
  assign tile.sync_reset = srst_q;
  assign tile.fifo_reset = frst_q;
  assign tile.read_pointer_reset = rprst_q;
  assign usr_rdata_a = tile.rdata_a;
  assign usr_rdata_b = tile.rdata_b;
  assign usr_full = tile.full;
  assign usr_empty = tile.empty;
  assign rst_busy = in_seq;
endmodule

/* hw/bmt_tile.sv */
`timescale 1ns/1ns
// How it works
// R1: widths 1,2,4,9 everywhere; 18 in pseudo/fifo
// R2: each port picks its own data width
// R3: bits packed lsb-first, word after word
// R4: optional preload from user flash store
// R5: zero image reads nothing; shared image base
// R6: preloaded with writes disabled acts as rom
// R7: address and write data registered before array
// R8: output register optional by parameter
// R9: fabric quiets enables around asynchronous resets
// R10: global set reset always acts asynchronously
// R11: otherwise clocks steady one period around reset
// R12: preloaded tile: global reset off or early
// R13: fifo keeps global reset; strobes act as enables
// R14: fabric sequences pointer and fifo resets
// R15: fifo and read pointer resets are asynchronous
// R16: sync reset without global reset needs nothing
// R17: read data one clock later, plus output stage
module bmt_tile #(
  parameter bmt_pkg::bmt_mode_e MODE = bmt_pkg::MODE_TDP,
  parameter int WIDTH_A = 9,
  parameter int WIDTH_B = 9,
  parameter bit OUT_REG = 1'b0,
  parameter bit PRELOAD = 1'b0,
  parameter bit INIT_ZERO = 1'b0,
  parameter int IMAGE_BASE = 0,
  parameter bit WRITE_EN = 1'b1,
  parameter bit GLOBAL_EN = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  bmt_if.tile port,
  output logic ufs_rd,
  output logic [bmt_pkg::UFS_AW-1:0] ufs_addr,
  input wire logic [bmt_pkg::INIT_W-1:0] ufs_data,
  output logic cfg_done
);
  import bmt_pkg::*;

  typedef enum logic {CFG_LOAD, CFG_RUN} bmt_cfg_e;

  localparam int DEPTH_A = bmt_depth(WIDTH_A);
  localparam int DEPTH_B = bmt_depth(WIDTH_B);
  localparam int CAP = bmt_cap(WIDTH_A);
  localparam bit IS_FIFO = (MODE == MODE_FIFO);

  // refuse widths and layouts the array cannot serve
  if (!bmt_width_ok(MODE, WIDTH_A) || !bmt_width_ok(MODE, WIDTH_B)) begin : g_bad_width
    $error("bmt_tile: port width not offered in this mode");               // [R1]
  end
  if (IS_FIFO && (bmt_cap(WIDTH_A) != bmt_cap(WIDTH_B))) begin : g_bad_fifo
    $error("bmt_tile: fifo port widths must share one width family");
  end
  if (IMAGE_BASE < 0 || IMAGE_BASE + INIT_WORDS > UFS_WORDS) begin : g_bad_base
    $error("bmt_tile: preload image does not fit the user flash store");
  end

  logic mem [0:MEM_BITS-1];
  bmt_cfg_e cfg_state;
  logic [INIT_IDX_W-1:0] ld_idx, ld_widx;
  logic ld_pend;
  logic a_ce_q, a_we_q, b_ce_q, b_we_q, push_q, pop_q;
  logic [ADDR_W-1:0] a_addr_q, b_addr_q;
  logic [DATA_W-1:0] a_wd_q, b_wd_q;
  logic [DATA_W-1:0] lat_a, lat_b, oreg_a, oreg_b;
  logic [PTR_W-1:0] wptr, rptr;

  // bit offset of a word: word index times the port's own width
  function automatic logic [BIT_W-1:0] bit_base(input logic [ADDR_W-1:0] addr, input int w,
                                                 input int depth);
    int prod;
    prod = (int'(addr) % depth) * w;
    return BIT_W'(prod);
  endfunction

  // gather one word from the array, lsb at the lowest bit offset
  function automatic logic [DATA_W-1:0] get_word(input logic [BIT_W-1:0] base, input int w);
    logic [DATA_W-1:0] r;
    r = DATA_ZERO;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < w) begin
        r[i] = mem[base + BIT_W'(i)];
      end
    end
    return r;
  endfunction

  // fifo pointer to bit offset
  function automatic logic [BIT_W-1:0] ptr_bit(input logic [PTR_W-1:0] p);
    return (int'(p) >= CAP) ? BIT_W'(int'(p) - CAP) : BIT_W'(p);
  endfunction

  // reset decode: global reset is honoured always in fifo mode
  wire glob_act = port.global_set_reset && (GLOBAL_EN || IS_FIFO);       // [R10] [R13]
  wire out_clr = glob_act || port.tile_async_reset;                       // [R10]
  wire wptr_clr = port.fifo_reset || glob_act;                            // [R15]
  wire rptr_clr = port.fifo_reset || port.read_pointer_reset || glob_act; // [R15]
  wire sync_clr = rst || port.sync_reset;                                 // [R16]

  // fifo fill level in bits, with pending strobes counted against it
  wire [PTR_W-1:0] fill = (wptr >= rptr) ? (wptr - rptr)
                        : PTR_W'(int'(wptr) + 2 * CAP - int'(rptr));
  wire full_now = (int'(fill) + WIDTH_A) > CAP;
  wire empty_now = int'(fill) < WIDTH_B;
  wire full_acc = (int'(fill) + (push_q ? 2 * WIDTH_A : WIDTH_A)) > CAP;
  wire empty_acc = int'(fill) < (pop_q ? 2 * WIDTH_B : WIDTH_B);

  // array-side decode from the registered inputs
  wire [BIT_W-1:0] base_a = IS_FIFO ? ptr_bit(wptr)
                          : bit_base(a_addr_q, WIDTH_A, DEPTH_A);         // [R3]
  wire [BIT_W-1:0] base_b = IS_FIFO ? ptr_bit(rptr)
                          : bit_base(b_addr_q, WIDTH_B, DEPTH_B);         // [R2] [R3]
  wire wr_a = IS_FIFO ? push_q
            : (a_ce_q && a_we_q && WRITE_EN);                             // [R6]
  wire wr_b = (MODE == MODE_TDP) && b_ce_q && b_we_q && WRITE_EN;         // [R6]
  wire rd_a = (MODE == MODE_SP || MODE == MODE_TDP) && a_ce_q && !a_we_q;
  wire rd_b = IS_FIFO ? pop_q
            : (MODE == MODE_PDP) ? b_ce_q
            : (MODE == MODE_TDP) && b_ce_q && !b_we_q;
  wire [INIT_W-1:0] ld_word = INIT_ZERO ? INIT_W'(0) : ufs_data;         // [R5]
  wire [BIT_W-1:0] ld_base = BIT_W'(int'(ld_widx) * INIT_W);

  // preload sequencing: zero images never touch the flash store
  assign ufs_rd = (cfg_state == CFG_LOAD) && !INIT_ZERO;                  // [R4] [R5]
  assign ufs_addr = UFS_AW'(IMAGE_BASE + int'(ld_idx));                   // [R5]
  assign cfg_done = (cfg_state == CFG_RUN) && !ld_pend;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_state <= PRELOAD ? CFG_LOAD : CFG_RUN;                          // [R4]
      ld_idx <= '0;
      ld_widx <= '0;
      ld_pend <= 1'b0;
    end else begin
      ld_pend <= (cfg_state == CFG_LOAD);
      ld_widx <= ld_idx;
      if (cfg_state == CFG_LOAD) begin
        ld_idx <= ld_idx + 1'b1;
        if (int'(ld_idx) == INIT_WORDS - 1) begin
          cfg_state <= CFG_RUN;
        end
      end
    end
  end

  // input stage: strobes, addresses and write data registered first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      a_ce_q <= 1'b0;
      b_ce_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
    end else begin
      a_ce_q <= port.ce_a && cfg_done;                                    // [R7]
      b_ce_q <= port.ce_b && cfg_done;                                    // [R7]
      push_q <= IS_FIFO && port.push && cfg_done && !full_acc && !wptr_clr;
      pop_q <= IS_FIFO && port.pop_strobe && cfg_done && !empty_acc && !rptr_clr;
    end
  end

  always_ff @(posedge clk_sys) begin
    a_we_q <= port.we_a;                                                  // [R7]
    b_we_q <= port.we_b;
    a_addr_q <= port.addr_a;
    b_addr_q <= port.addr_b;
    a_wd_q <= port.wdata_a;
    b_wd_q <= port.wdata_b;
  end

  // array writes: preload, then port a, then port b (b wins a collision)
  always_ff @(posedge clk_sys) begin
    if (ld_pend) begin
      for (int i = 0; i < INIT_W; i++) begin
        mem[ld_base + BIT_W'(i)] <= ld_word[i];                           // [R4]
      end
    end
    if (wr_a) begin
      for (int i = 0; i < WIDTH_A; i++) begin
        mem[base_a + BIT_W'(i)] <= a_wd_q[i];                             // [R3]
      end
    end
    if (wr_b) begin
      for (int i = 0; i < WIDTH_B; i++) begin
        mem[base_b + BIT_W'(i)] <= b_wd_q[i];
      end
    end
  end

  // fifo pointers, cleared asynchronously by their own resets
  always_ff @(posedge clk_sys or posedge wptr_clr) begin
    if (wptr_clr) begin
      wptr <= '0;                                                         // [R15]
    end else if (rst) begin
      wptr <= '0;
    end else if (push_q) begin
      wptr <= bmt_ptr_adv(wptr, WIDTH_A, CAP);
    end
  end

  always_ff @(posedge clk_sys or posedge rptr_clr) begin
    if (rptr_clr) begin
      rptr <= '0;                                                         // [R15]
    end else if (rst) begin
      rptr <= '0;
    end else if (pop_q) begin
      rptr <= bmt_ptr_adv(rptr, WIDTH_B, CAP);
    end
  end

  // array output latch and optional output register
  always_ff @(posedge clk_sys or posedge out_clr) begin
    if (out_clr) begin
      lat_a <= DATA_ZERO;                                                 // [R10]
      lat_b <= DATA_ZERO;
      oreg_a <= DATA_ZERO;
      oreg_b <= DATA_ZERO;
    end else if (sync_clr) begin
      lat_a <= DATA_ZERO;                                                 // [R16]
      lat_b <= DATA_ZERO;
      oreg_a <= DATA_ZERO;
      oreg_b <= DATA_ZERO;
    end else begin
      if (rd_a) begin
        lat_a <= get_word(base_a, WIDTH_A);                               // [R17]
      end
      if (rd_b) begin
        lat_b <= get_word(base_b, WIDTH_B);                               // [R17]
      end
      oreg_a <= lat_a;
      oreg_b <= lat_b;
    end
  end

  // read data selection and fifo status
  assign port.rdata_a = OUT_REG ? oreg_a : lat_a;                         // [R8]
  assign port.rdata_b = OUT_REG ? oreg_b : lat_b;                         // [R8] [R17]
  assign port.full = IS_FIFO && full_now;
  assign port.empty = !IS_FIFO || empty_now;
endmodule

/* dv/bmt_monitor.sv */
`timescale 1ns/1ns
// watches the tile link: reset sequencing duties and read data behaviour
module bmt_monitor #(
  parameter int WIDTH_A = 9,
  parameter int WIDTH_B = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce_a,
  input wire logic ce_b,
  input wire logic push,
  input wire logic pop_strobe,
  input wire logic [bmt_pkg::DATA_W-1:0] rdata_a,
  input wire logic [bmt_pkg::DATA_W-1:0] rdata_b,
  input wire logic global_set_reset,
  input wire logic tile_async_reset,
  input wire logic sync_reset,
  input wire logic fifo_reset,
  input wire logic read_pointer_reset
);
  import bmt_pkg::*;

  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // both ram ports idle, and either asynchronous clear active
  wire quiet_ab = !ce_a && !ce_b;
  wire any_async = global_set_reset || tile_async_reset;

  quiet_before_async_a:
    assert property ($rose(tile_async_reset) |-> quiet_ab && $past(quiet_ab))
    else $error("port enable active as the tile reset rose");
  quiet_after_async_a:
    assert property ($fell(tile_async_reset) |-> quiet_ab)
    else $error("port enable active as the tile reset fell");
  quiet_around_global_a:
    assert property (($rose(global_set_reset) || $fell(global_set_reset)) |-> quiet_ab)
    else $error("port enable active around the global reset edges");
  gsr_clears_a:
    assert property (global_set_reset |-> rdata_a == '0 && rdata_b == '0)
    else $error("global reset left read data standing");
  async_clears_a:
    assert property (tile_async_reset |-> rdata_a == '0 && rdata_b == '0)
    else $error("tile reset left read data standing");
  fifo_rst_quiet_a:
    assert property ((fifo_reset || $fell(fifo_reset)) |->
      !push && !pop_strobe && !$past(push) && !$past(pop_strobe))
    else $error("fifo strobes active around the fifo reset");
  rptr_quiet_a:
    assert property ((read_pointer_reset || $fell(read_pointer_reset)) |->
      !pop_strobe && !$past(pop_strobe))
    else $error("pop strobe active around the read pointer reset");
  sync_clears_a:
    assert property (sync_reset && quiet_ab |=> rdata_a == '0 && rdata_b == '0)
    else $error("sync reset did not clear read data");
  read_hold_a:
    assert property (!$past(ce_b, 2) && !$past(sync_reset) && !$past(any_async) && !any_async
      |-> $stable(rdata_b))
    else $error("port b read data changed without a read");
  width_a_a:
    assert property ((rdata_a >> WIDTH_A) == '0)
    else $error("port a read data wider than its port");

  // main scenarios reached
  cover property ($rose(tile_async_reset));
  cover property ($rose(global_set_reset));
  cover property (sync_reset);
  cover property ($rose(read_pointer_reset));
endmodule

/* dv/tb_embedded_block_ram.sv */
`timescale 1ns/1ns
// drives the fabric side of the joined pair and checks the tile's answers
module tb_embedded_block_ram;
  import bmt_pkg::*;

  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic usr_ce_a = 1'h0, usr_we_a = 1'h0, usr_ce_b = 1'h0, usr_we_b = 1'h0;
  logic [ADDR_W-1:0] usr_addr_a = '0, usr_addr_b = '0;
  logic [DATA_W-1:0] usr_wdata_a = '0, usr_wdata_b = '0, usr_rdata_a, usr_rdata_b;
  logic usr_push = 1'h0, usr_pop = 1'h0, usr_full, usr_empty;
  logic rst_req = 1'h0, rst_busy, rst_refused, cfg_done;
  bmt_rkind_e rst_kind = RK_ASYNC;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  bmt_rkind_e kinds [5] = '{RK_ASYNC, RK_GLOBAL, RK_SYNC, RK_FIFO, RK_RPTR};
  bit clears [5] = '{1, 1, 1, 0, 0};
  logic [DATA_W-1:0] pat_a = 18'h0_01a5;
  logic [DATA_W-1:0] pat_b = 18'h0_0163;
  logic f_push = 1'h0, f_pop = 1'h0, f_req = 1'h0;
  logic f_full, f_empty, f_busy, f_refused, f_done, f_ufs_rd;
  logic [DATA_W-1:0] f_wdata = '0, f_rdata;
  bmt_rkind_e f_kind = RK_FIFO;

  bmt_if link();
  // second pair: fifo with output stage and a zero preload image
  bmt_if link_f();

  bmt_tile #(.MODE(MODE_FIFO), .WIDTH_A(9), .WIDTH_B(9), .OUT_REG(1'b1), .PRELOAD(1'b1),
    .INIT_ZERO(1'b1)) i_bmt_tile_f (
    .clk_sys(clk_sys), .rst(rst), .port(link_f.tile), .ufs_rd(f_ufs_rd), .ufs_addr(),
    .ufs_data('0), .cfg_done(f_done));

  bmt_user #(.MODE(MODE_FIFO), .PRELOADED(1'b1)) i_bmt_user_f (
    .clk_sys(clk_sys), .rst(rst), .tile(link_f.user),
    .usr_ce_a(1'h0), .usr_we_a(1'h0), .usr_addr_a('0), .usr_wdata_a(f_wdata),
    .usr_rdata_a(), .usr_ce_b(1'h0), .usr_we_b(1'h0), .usr_addr_b('0),
    .usr_wdata_b('0), .usr_rdata_b(f_rdata),
    .usr_push(f_push), .usr_pop(f_pop), .usr_full(f_full), .usr_empty(f_empty),
    .rst_req(f_req), .rst_kind(f_kind), .rst_busy(f_busy), .rst_refused(f_refused));

  bmt_tile #(.MODE(MODE_TDP), .WIDTH_A(1), .WIDTH_B(9)) i_bmt_tile (
    .clk_sys(clk_sys), .rst(rst), .port(link.tile), .ufs_rd(), .ufs_addr(),
    .ufs_data('0), .cfg_done(cfg_done));

  bmt_user #(.MODE(MODE_TDP)) i_bmt_user (
    .clk_sys(clk_sys), .rst(rst), .tile(link.user),
    .usr_ce_a(usr_ce_a), .usr_we_a(usr_we_a), .usr_addr_a(usr_addr_a),
    .usr_wdata_a(usr_wdata_a), .usr_rdata_a(usr_rdata_a),
    .usr_ce_b(usr_ce_b), .usr_we_b(usr_we_b), .usr_addr_b(usr_addr_b),
    .usr_wdata_b(usr_wdata_b), .usr_rdata_b(usr_rdata_b),
    .usr_push(usr_push), .usr_pop(usr_pop), .usr_full(usr_full), .usr_empty(usr_empty),
    .rst_req(rst_req), .rst_kind(rst_kind), .rst_busy(rst_busy), .rst_refused(rst_refused));

  bmt_monitor #(.WIDTH_A(1), .WIDTH_B(9)) i_bmt_monitor (
    .clk_sys(clk_sys), .rst(rst), .ce_a(link.ce_a), .ce_b(link.ce_b), .push(link.push),
    .pop_strobe(link.pop_strobe), .rdata_a(link.rdata_a), .rdata_b(link.rdata_b),
    .global_set_reset(link.global_set_reset), .tile_async_reset(link.tile_async_reset),
    .sync_reset(link.sync_reset), .fifo_reset(link.fifo_reset),
    .read_pointer_reset(link.read_pointer_reset));

  // 20 mhz clock
  always #25 clk_sys = ~clk_sys;

  // hang guard, far above the roughly 1100 cycles the tests take, preload included
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_data(input string name, input logic [DATA_W-1:0] exp,
                          input logic [DATA_W-1:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask

  // one access on port a (pb=0) or b, returns once read data have landed
  task automatic acc(input bit pb, input bit w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    usr_ce_a <= !pb;
    usr_ce_b <= pb;
    usr_we_a <= w & !pb;
    usr_we_b <= w & pb;
    usr_addr_a <= a;
    usr_addr_b <= a;
    usr_wdata_a <= d;
    usr_wdata_b <= d;
    @(posedge clk_sys);
    usr_ce_a <= 1'h0;
    usr_ce_b <= 1'h0;
    usr_we_a <= 1'h0;
    usr_we_b <= 1'h0;
    @(posedge clk_sys);
    #1;
  endtask

  // one push (pop=0) or pop on the fifo pair, returns just after the edge at which the pointer moves
  task automatic f_strobe(input bit pop, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    f_push <= !pop;
    f_pop <= pop;
    f_wdata <= d;
    @(posedge clk_sys);
    f_push <= 1'h0;
    f_pop <= 1'h0;
    @(posedge clk_sys);
    #1;
  endtask

  // one reset request on the fifo pair, waits until its sequence ends
  task automatic f_ask(input bmt_rkind_e k);
    int n;
    n = 0;
    @(posedge clk_sys);
    f_req <= 1'h1;
    f_kind <= k;
    @(posedge clk_sys);
    f_req <= 1'h0;
    #1;
    while (f_busy === 1'h1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
  endtask

  // asks for one reset sequence while port a keeps reading address 0
  task automatic seq(input int k);
    int n;
    n = 0;
    @(posedge clk_sys);
    usr_ce_a <= 1'h1;
    usr_addr_a <= '0;
    rst_req <= 1'h1;
    rst_kind <= kinds[k];
    @(posedge clk_sys);
    rst_req <= 1'h0;
    #1;
    chk_flag("reset busy", 1'h1, rst_busy);
    chk_flag("reset refused", 1'h0, rst_refused);
    while (rst_busy === 1'h1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    chk_flag("reset finished", 1'h0, rst_busy);
    chk_data("port b after reset", clears[k] ? '0 : pat_a, usr_rdata_b);
    @(posedge clk_sys);
    usr_ce_a <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk_data("port a reads resumed", 18'h0_0001, usr_rdata_a);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk_flag("cfg done", 1'h1, cfg_done);
    chk_flag("empty outside fifo", 1'h1, usr_empty);
    chk_flag("full outside fifo", 1'h0, usr_full);
    chk_data("port b at reset", '0, usr_rdata_b);
    chk_flag("preload running", 1'h0, f_done);
    chk_flag("zero image leaves flash idle", 1'h0, f_ufs_rd);
    // narrow writes on a, wide read on b: bit i of word 0 is a-address i
    for (int i = 0; i < 9; i++) begin
      acc(1'h0, 1'h1, ADDR_W'(i), {17'h0_0000, pat_a[i]});
    end
    acc(1'h1, 1'h0, '0, '0);
    chk_data("b word 0", pat_a, usr_rdata_b);
    // wide write on b, narrow reads on a
    acc(1'h1, 1'h1, 13'h0001, pat_b);
    for (int i = 0; i < 9; i++) begin
      acc(1'h0, 1'h0, ADDR_W'(9 + i), '0);
      chk_data("a bit of b word 1", {17'h0_0000, pat_b[i]}, usr_rdata_a);
    end
    // each reset kind in turn, port b loaded beforehand
    for (int k = 0; k < 5; k++) begin
      acc(1'h1, 1'h0, '0, '0);
      chk_data("b reload", pat_a, usr_rdata_b);
      seq(k);
    end
    acc(1'h1, 1'h0, '0, '0);
    chk_data("contents kept over resets", pat_a, usr_rdata_b);
    // fifo pair: preload ends, a word passes the output stage, global reset is refused, fifo reset empties
    while (f_done !== 1'h1) begin
      @(posedge clk_sys);
      #1;
    end
    chk_flag("fifo empty after preload", 1'h1, f_empty);
    f_strobe(1'h0, pat_b);
    chk_flag("fifo holds a word", 1'h0, f_empty);
    chk_flag("fifo not full", 1'h0, f_full);
    f_strobe(1'h1, '0);
    chk_data("pop before output stage", '0, f_rdata);
    @(posedge clk_sys);
    #1;
    chk_data("pop through output stage", pat_b, f_rdata);
    chk_flag("fifo drained", 1'h1, f_empty);
    f_ask(RK_GLOBAL);
    chk_flag("global reset refused", 1'h1, f_refused);
    chk_flag("refused request idle", 1'h0, f_busy);
    f_strobe(1'h0, pat_a);
    chk_flag("fifo refilled", 1'h0, f_empty);
    f_ask(RK_FIFO);
    chk_flag("fifo reset empties", 1'h1, f_empty);
    give_verdict();
  end
endmodule
